// file: logic/trap_top.sv
// trap_top: process-image register access port of a two-channel pwm terminal
// assumes: AXI4-Lite master writes control/data words, reads status/data
`timescale 1ns/1ps
module trap_top #(
	parameter logic [15:0] TYPE_ID = 16'h1234, // arbitrary identifier value
	parameter logic [15:0] FIRMWARE_ID = 16'h0001 // arbitrary version value
) (
	input wire logic REF_CLK, // 10 MHz clock
	input wire logic RESET_N, // synchronous reset, active low
	input wire logic [3:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [3:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	output logic [15:0] CH1_PROCESS_VALUE, // channel 1 pwm setpoint
	output logic [15:0] CH2_PROCESS_VALUE, // channel 2 pwm setpoint
	output logic REGS_UNLOCKED // user registers writable
);
	// outbound image, one word per channel: control, data low, data high
	logic [7:0] channel_control_byte [trap_pkg::CHANNELS];
	logic [7:0] data_low_byte [trap_pkg::CHANNELS];
	logic [7:0] data_high_byte [trap_pkg::CHANNELS];
	logic [7:0] channel_status_byte [trap_pkg::CHANNELS];
	logic [15:0] data_in_word [trap_pkg::CHANNELS];
	logic [15:0] process_value [trap_pkg::CHANNELS];
	logic [7:0] last_control [trap_pkg::CHANNELS];
	logic ctrl_changed [trap_pkg::CHANNELS];
	logic [15:0] reg_file [trap_pkg::REG_COUNT];
	logic unlocked;
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire do_write = aw_held && w_held && !S_AXI_BVALID;
	wire do_read = S_AXI_ARVALID && S_AXI_ARREADY;
	wire write_ch1 = aw_addr == trap_pkg::ADDR_CH1_OUT;
	wire write_ch2 = aw_addr == trap_pkg::ADDR_CH2_OUT;
	wire write_hit = write_ch1 || write_ch2;
	// access engine: one channel served at a time, channel 1 first
	trap_pkg::trap_acc_type state;
	trap_pkg::trap_acc_type next_state;
	logic acc_ch;
	logic [7:0] acc_ctrl;
	logic [15:0] acc_data;
	wire [5:0] acc_index = acc_ctrl[trap_pkg::IDX_W-1:0];
	wire acc_is_write = acc_ctrl[trap_pkg::BIT_WRITE];
	wire pend0 = ctrl_changed[0];
	wire pend1 = ctrl_changed[1];
	wire start = state == trap_pkg::ST_IDLE && (pend0 || pend1);
	wire start_ch = !pend0;
	wire write_allowed = unlocked || acc_index == trap_pkg::REG_CODE_WORD;
	wire [15:0] read_value =
		acc_index == trap_pkg::REG_TYPE_ID ? TYPE_ID :
		acc_index == trap_pkg::REG_FIRMWARE ? FIRMWARE_ID :
		reg_file[acc_index];

	always_comb
	begin
		next_state = state;
		case (state)
			trap_pkg::ST_IDLE:
				if (start)
					next_state = trap_pkg::ST_ACCESS;
			trap_pkg::ST_ACCESS:
				next_state = trap_pkg::ST_ANSWER;
			trap_pkg::ST_ANSWER:
				next_state = trap_pkg::ST_IDLE;
			default:
				next_state = trap_pkg::ST_IDLE;
		endcase
	end

	// axi write channels: address and data taken in either order
	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			// readies are flops that hold the complement of the held flags
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= trap_pkg::RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_held <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_held <= 1'b1;
				S_AXI_WREADY <= 1'b0;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= write_hit ? trap_pkg::RESP_OKAY :
					trap_pkg::RESP_SLVERR;
			end
			else if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// per-channel output image and change detection
	generate
		for (genvar ch = 0; ch < trap_pkg::CHANNELS; ch++)
		begin : g_ch
			wire hit = do_write && (ch == 0 ? write_ch1 : write_ch2);
			wire served = state == trap_pkg::ST_ANSWER && acc_ch == ch;
			always_ff @(posedge REF_CLK)
			begin
				if (!RESET_N)
				begin
					channel_control_byte[ch] <= 8'h00;
					data_low_byte[ch] <= 8'h00;
					data_high_byte[ch] <= 8'h00;
					process_value[ch] <= 16'h0000;
					last_control[ch] <= 8'h00;
					ctrl_changed[ch] <= 1'b0;
					channel_status_byte[ch] <= trap_pkg::STATUS_RESET;
					data_in_word[ch] <= 16'h0000;
				end
				else
				begin
					if (hit && w_strb[0])
						channel_control_byte[ch] <= w_data[7:0];
					if (hit && w_strb[1])
						data_low_byte[ch] <= w_data[15:8];
					if (hit && w_strb[2])
						data_high_byte[ch] <= w_data[23:16];
					// register mode freezes the pwm value
					if (!channel_control_byte[ch][trap_pkg::BIT_REGMODE])
					begin
						process_value[ch] <=
							{data_high_byte[ch], data_low_byte[ch]};
						channel_status_byte[ch] <= channel_control_byte[ch];
						last_control[ch] <= channel_control_byte[ch];
						data_in_word[ch] <= 16'h0000;
					end
					// a new control value requests one access; clear wins
					if (channel_control_byte[ch][trap_pkg::BIT_REGMODE]
						&& channel_control_byte[ch] != last_control[ch]
						&& !(start && start_ch == ch))
					begin
						ctrl_changed[ch] <= 1'b1;
						last_control[ch] <= channel_control_byte[ch];
					end
					else if (start && start_ch == ch)
						ctrl_changed[ch] <= 1'b0;
					if (served)
					begin
						if (acc_is_write)
						begin
							channel_status_byte[ch] <= acc_ctrl &
								~(8'h01 << trap_pkg::BIT_WRITE);
							data_in_word[ch] <= 16'h0000;
						end
						else
						begin
							channel_status_byte[ch] <= acc_ctrl;
							data_in_word[ch] <= read_value;
						end
					end
				end
			end
		end
	endgenerate

	// access engine and register set
	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			state <= trap_pkg::ST_IDLE;
			acc_ch <= 1'b0;
			acc_ctrl <= 8'h00;
			acc_data <= 16'h0000;
			unlocked <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (start)
			begin
				acc_ch <= start_ch;
				acc_ctrl <= last_control[start_ch];
				acc_data <= {data_high_byte[start_ch],
					data_low_byte[start_ch]};
			end
			if (state == trap_pkg::ST_ACCESS && acc_is_write
				&& acc_index == trap_pkg::REG_CODE_WORD)
				unlocked <= acc_data == trap_pkg::CODE_WORD_UNLOCK;
		end
	end

	// the register array has no reset so it can map onto plain storage
	always_ff @(posedge REF_CLK)
	begin
		if (state == trap_pkg::ST_ACCESS && acc_is_write && write_allowed)
			reg_file[acc_index] <= acc_data;
	end

	// axi read channel: an out and an in word per channel, control or status in low byte
	wire [3:0] rd_addr = S_AXI_ARADDR;
	wire [31:0] rd_word =
		rd_addr == trap_pkg::ADDR_CH1_OUT ? {8'h00, data_high_byte[0],
			data_low_byte[0], channel_control_byte[0]} :
		rd_addr == trap_pkg::ADDR_CH2_OUT ? {8'h00, data_high_byte[1],
			data_low_byte[1], channel_control_byte[1]} :
		rd_addr == trap_pkg::ADDR_CH1_IN ? {8'h00, data_in_word[0],
			channel_status_byte[0]} :
		{8'h00, data_in_word[1], channel_status_byte[1]};

	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= trap_pkg::RESP_OKAY;
			S_AXI_ARREADY <= 1'b0;
		end
		else
		begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
			if (do_read)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_word;
				S_AXI_RRESP <= rd_addr[1:0] == 2'b00 ?
					trap_pkg::RESP_OKAY : trap_pkg::RESP_SLVERR;
				S_AXI_ARREADY <= 1'b0;
			end
			else if (S_AXI_RVALID && S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			CH1_PROCESS_VALUE <= 16'h0000;
			CH2_PROCESS_VALUE <= 16'h0000;
			REGS_UNLOCKED <= 1'b0;
		end
		else
		begin
			CH1_PROCESS_VALUE <= process_value[0];
			CH2_PROCESS_VALUE <= process_value[1];
			REGS_UNLOCKED <= unlocked;
		end
	end

	AST_ACK_WRITE: assert property (@(posedge REF_CLK)
		disable iff (!RESET_N)
		state == trap_pkg::ST_ANSWER && acc_is_write && acc_ch == 1'b0
		|=> channel_status_byte[0] == {acc_ctrl[7], 1'b0, acc_ctrl[5:0]})
		else $error("write ack not control with bit 6 clear");
	AST_ECHO_READ: assert property (@(posedge REF_CLK)
		disable iff (!RESET_N)
		state == trap_pkg::ST_ANSWER && !acc_is_write && acc_ch == 1'b0
		|=> channel_status_byte[0] == $past(acc_ctrl))
		else $error("read status does not echo control");
	AST_HOLD_PWM: assert property (@(posedge REF_CLK)
		disable iff (!RESET_N)
		channel_control_byte[0][7] && $past(channel_control_byte[0][7])
		|-> $stable(process_value[0]))
		else $error("process value moved in register mode");
	// compare with the stored word itself: registers 8 and 9 read constants
	AST_LOCK: assert property (@(posedge REF_CLK)
		disable iff (!RESET_N)
		state == trap_pkg::ST_ACCESS && acc_is_write && !unlocked
		&& acc_index != trap_pkg::REG_CODE_WORD
		|=> reg_file[$past(acc_index)] == $past(reg_file[acc_index]))
		else $error("locked register was written");
	AST_UNLOCK: assert property (@(posedge REF_CLK)
		disable iff (!RESET_N)
		state == trap_pkg::ST_ACCESS && acc_is_write
		&& acc_index == trap_pkg::REG_CODE_WORD
		|=> unlocked == ($past(acc_data) == trap_pkg::CODE_WORD_UNLOCK))
		else $error("code word did not set lock state");
	AST_SEQ: assert property (@(posedge REF_CLK)
		disable iff (!RESET_N)
		start |=> state == trap_pkg::ST_ACCESS ##1
		state == trap_pkg::ST_ANSWER ##1 state == trap_pkg::ST_IDLE)
		else $error("access sequence broken");
	AST_READ_DATA: assert property (@(posedge REF_CLK)
		disable iff (!RESET_N)
		state == trap_pkg::ST_ANSWER && !acc_is_write && acc_ch == 1'b1
		|=> data_in_word[1] == $past(read_value))
		else $error("read data not returned");
	AST_BRESP: assert property (@(posedge REF_CLK)
		disable iff (!RESET_N)
		do_write |=> S_AXI_BVALID)
		else $error("write response missing");
	// an answer landing in the same cycle outranks the process mirror
	AST_MIRROR: assert property (@(posedge REF_CLK)
		disable iff (!RESET_N)
		!channel_control_byte[1][trap_pkg::BIT_REGMODE]
		&& !(state == trap_pkg::ST_ANSWER && acc_ch == 1'b1)
		|=> channel_status_byte[1] == $past(channel_control_byte[1])
		&& data_in_word[1] == 16'h0000)
		else $error("process mode status does not mirror control");
endmodule // trap_top

// file: logic/trap_pkg.sv
// trap_pkg: constants for the two-channel terminal register access port
// assumes: a single 10 MHz clock domain, AXI4-Lite at the software side
package trap_pkg;
	localparam int CHANNELS = 2;
	localparam int REG_COUNT = 64;
	localparam int IDX_W = 6;
	localparam int BIT_REGMODE = 7;
	localparam int BIT_WRITE = 6;
	localparam logic [5:0] REG_TYPE_ID = 6'h08;
	localparam logic [5:0] REG_FIRMWARE = 6'h09;
	localparam logic [5:0] REG_CODE_WORD = 6'h1f;
	localparam logic [15:0] CODE_WORD_UNLOCK = 16'h1235;
	localparam logic [15:0] USER_REG_RESET = 16'h0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// byte addresses of the software-visible words
	localparam logic [3:0] ADDR_CH1_OUT = 4'h0;
	localparam logic [3:0] ADDR_CH2_OUT = 4'h4;
	localparam logic [3:0] ADDR_CH1_IN = 4'h8;
	localparam logic [3:0] ADDR_CH2_IN = 4'hc;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACCESS = 2'b01,
		ST_ANSWER = 2'b10
	} trap_acc_type;
endpackage

// file: testbench/trap_coupler.sv
// trap_coupler: coupler-side master moving image words over AXI4-Lite
// assumes: one clock; the bench watchdog ends any wait that never ends
`timescale 1ns/1ps
module trap_coupler (
	input wire logic clk, // bus clock
	output logic [3:0] awaddr, // write address
	output logic awvalid, // write address valid
	input wire logic awready, // write address ready
	output logic [31:0] wdata, // write data
	output logic [3:0] wstrb, // write strobes
	output logic wvalid, // write data valid
	input wire logic wready, // write data ready
	input wire logic [1:0] bresp, // write response
	input wire logic bvalid, // response valid
	output logic bready, // response ready
	output logic [3:0] araddr, // read address
	output logic arvalid, // read address valid
	input wire logic arready, // read address ready
	input wire logic [31:0] rdata, // read data
	input wire logic [1:0] rresp, // read response
	input wire logic rvalid, // read valid
	output logic rready // read ready
);
	// ready lines stay high: the coupler never stalls an answer
	initial
	begin
		awaddr = 4'h0;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b1;
		araddr = 4'h0;
		arvalid = 1'b0;
		rready = 1'b1;
	end

	// handshakes are judged at the rising edge, on the values it samples
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		while (!tb);
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			if (ta)
				arvalid <= 1'b0;
		end
		while (!tr);
	endtask

	// control byte lowest, then data low, data high
	task automatic put(input int ch, input logic [7:0] c,
		input logic [15:0] v, output logic [1:0] r);
		wr(ch == 1 ? trap_pkg::ADDR_CH1_OUT : trap_pkg::ADDR_CH2_OUT,
			{8'h00, v, c}, r);
	endtask

	// status byte only ever comes back in the input words
	task automatic get(input int ch, output logic [31:0] d,
		output logic [1:0] r);
		rd(ch == 1 ? trap_pkg::ADDR_CH1_IN : trap_pkg::ADDR_CH2_IN, d, r);
	endtask

	// split a coupler output image (byte 0 lowest) into terminal words
	// fmt[0] big-endian, fmt[1] word aligned, fmt[2] control byte hidden
	task automatic put_image(input logic [63:0] img, input logic [2:0] fmt,
		output logic [1:0] r);
		int base;
		logic [7:0] c;
		logic [15:0] v;
		for (int ch = 0; ch < 2; ch++)
		begin
			// aligned: control in low byte of an even word, reserved byte next
			base = fmt[1] ? 32 * ch : 24 * ch;
			// the default ring mapping keeps control away from the fieldbus
			c = fmt[2] ? 8'h00 : img[base +: 8];
			base = fmt[1] ? base + 16 : base + 8;
			v = fmt[0] ? {img[base +: 8], img[base + 8 +: 8]} :
				{img[base + 8 +: 8], img[base +: 8]};
			put(ch + 1, c, v, r);
		end
	endtask
endmodule // trap_coupler

// file: testbench/test_terminal_register_access_port.sv
// test_terminal_register_access_port: self-checking bench of trap_top
// assumes: trap_coupler masters the bus; 10 MHz clock, sync reset
`timescale 1ns/1ps
module test_terminal_register_access_port;
	// identifier and version values are arbitrary
	localparam logic [15:0] TYPE_VAL = 16'h5a3c;
	localparam logic [15:0] FW_VAL = 16'h0102;
	logic ref_clk, reset_n, awvalid, awready, wvalid, wready, bvalid;
	logic bready, arvalid, arready, rvalid, rready, unlocked;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [15:0] ch1, ch2;
	int err_count, comparisons;

	trap_top #(.TYPE_ID(TYPE_VAL), .FIRMWARE_ID(FW_VAL)) dut (
		.REF_CLK(ref_clk), .RESET_N(reset_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .CH1_PROCESS_VALUE(ch1),
		.CH2_PROCESS_VALUE(ch2), .REGS_UNLOCKED(unlocked));

	trap_coupler cpl (
		.clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));

	always #50 ref_clk = ~ref_clk;

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// the answer lands a few cycles late, so poll a bounded number of reads
	task automatic poll(input int ch, input logic [7:0] st,
		output logic [31:0] w);
		logic [1:0] rr;
		int n;
		n = 0;
		do
		begin
			cpl.get(ch, w, rr);
			n++;
		end
		while (w[7:0] !== st && n < 16);
		check_val({24'h0, w[7:0]}, {24'h0, st});
	endtask

	// pass through process mode first so every access byte is a fresh one
	task automatic access(input int ch, input logic [7:0] c,
		input logic [15:0] v, input logic [7:0] st, output logic [31:0] w);
		logic [1:0] rr;
		cpl.put(ch, 8'h3f, ch == 1 ? 16'ha55a : 16'h0c3c, rr);
		poll(ch, 8'h3f, w);
		cpl.put(ch, c, v, rr);
		poll(ch, st, w);
	endtask

	initial
	begin
		#(20000 * 100);
		err_count++;
		give_verdict();
	end

	initial
	begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		err_count = 0;
		comparisons = 0;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		cpl.get(1, d, r);
		check_val(d, 32'h0);
		check_resp(r, trap_pkg::RESP_OKAY);
		check_val({ch2, ch1}, 32'h0);
		check_val({31'h0, unlocked}, 32'h0);
		done("reset");
		cpl.put(1, 8'h3f, 16'ha55a, r);
		check_resp(r, trap_pkg::RESP_OKAY);
		cpl.put(2, 8'h3f, 16'h0c3c, r);
		poll(1, 8'h3f, d);
		check_val(d, 32'h0000003f);
		poll(2, 8'h3f, d);
		check_val({ch2, ch1}, 32'h0c3ca55a);
		done("process");
		cpl.put_image(64'h00005678_3f12343f, 3'd0, r);
		cpl.get(2, d, r);
		check_val({ch2, ch1}, 32'h56781234);
		cpl.put_image(64'h0000f0de_3fbc9a3f, 3'd1, r);
		cpl.get(2, d, r);
		check_val({ch2, ch1}, 32'hdef09abc);
		cpl.put_image(64'h0304003f_0102003f, 3'd2, r);
		cpl.get(2, d, r);
		check_val({ch2, ch1}, 32'h03040102);
		cpl.put_image(64'h0807003f_0605003f, 3'd3, r);
		cpl.get(2, d, r);
		check_val({ch2, ch1}, 32'h07080506);
		cpl.put_image(64'h00003344_88112288, 3'd4, r);
		cpl.get(1, d, r);
		check_val(d, 32'h0);
		check_val({ch2, ch1}, 32'h33441122);
		done("image");
		access(1, 8'h88, 16'hffff, 8'h88, d);
		check_val(d, {8'h00, TYPE_VAL, 8'h88});
		access(2, 8'h89, 16'h0000, 8'h89, d);
		check_val(d, {8'h00, FW_VAL, 8'h89});
		check_val({ch2, ch1}, 32'h0c3ca55a);
		done("read");
		access(1, 8'hdf, 16'h1235, 8'h9f, d);
		check_val({ch1, 15'h0, unlocked}, 32'ha55a0001);
		access(1, 8'h9f, 16'h0000, 8'h9f, d);
		check_val(d, 32'h0012359f);
		done("unlock");
		access(1, 8'he0, 16'h0002, 8'ha0, d);
		cpl.put(1, 8'he0, 16'h0005, r);
		access(1, 8'ha0, 16'h0000, 8'ha0, d);
		check_val(d, 32'h000002a0);
		done("repeat");
		access(1, 8'hdf, 16'h0000, 8'h9f, d);
		check_val({31'h0, unlocked}, 32'h0);
		access(1, 8'he0, 16'h0077, 8'ha0, d);
		access(1, 8'ha0, 16'h0000, 8'ha0, d);
		check_val(d, 32'h000002a0);
		done("relock");
		cpl.wr(trap_pkg::ADDR_CH1_IN, 32'h000000ff, r);
		check_resp(r, trap_pkg::RESP_SLVERR);
		cpl.wr(4'h1, 32'h000000ff, r);
		check_resp(r, trap_pkg::RESP_SLVERR);
		cpl.rd(4'h2, d, r);
		check_resp(r, trap_pkg::RESP_SLVERR);
		cpl.get(1, d, r);
		check_val(d, 32'h000002a0);
		done("refuse");
		give_verdict();
	end
endmodule // test_terminal_register_access_port
